/* logic/program_space_data_window.v */
// Data-space window onto program memory with trap and stall timing
`timescale 1ns/1ns
`default_nettype none
`include "program_space_data_window_consts.vh"

module program_space_data_window (
    input  wire                        sys_clk,
    input  wire                        rst_n,
    input  wire                        acc_valid,
    input  wire                        acc_write,
    input  wire                        acc_byte,
    input  wire [`EFF_ADDR_W-1:0]      effective_address,
    input  wire [`DATA_W-1:0]          acc_wdata,
    input  wire [`PAGE_W-1:0]          read_page_register,
    input  wire [`PAGE_W-1:0]          write_page_register,
    input  wire                        kind_move,
    input  wire                        in_repeat,
    input  wire                        repeat_first,
    input  wire                        repeat_last,
    input  wire                        repeat_int_exit,
    input  wire                        repeat_int_reentry,
    input  wire [`PROG_DATA_W-1:0]     prog_rdata,
    input  wire [`DATA_W-1:0]          data_rdata,
    output reg                         busy,
    output reg                         resp_valid,
    output reg  [`DATA_W-1:0]          resp_data,
    output reg                         addr_err_trap,
    output reg                         prog_rd,
    output reg  [`PROG_ADDR_W-1:0]     prog_addr,
    output reg                         prog_upper,
    output reg                         data_rd,
    output reg                         data_wr,
    output reg  [`EFF_ADDR_W-1:0]      data_addr,
    output reg  [1:0]                  data_be,
    output reg  [`DATA_W-1:0]          data_wdata
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_CAPT  = 2'h2;
    localparam [1:0] ST_WAIT  = 2'h3;

    // ****************************************************************
    // Decoding functions
    // ****************************************************************
    // Window access aimed at program memory
    function route_prog;
        input [`EFF_ADDR_W-1:0] eff;
        input [`PAGE_W-1:0]     page;
        input                   wr;
        begin
            route_prog = eff[`EFF_WINDOW_BIT] &
                         page[`PAGE_ROUTE_BIT] & ~wr;
        end
    endfunction

    // Window access with an empty page
    function zero_page_trap;
        input [`EFF_ADDR_W-1:0] eff;
        input [`PAGE_W-1:0]     page;
        begin
            zero_page_trap = eff[`EFF_WINDOW_BIT] &
                             (page == `TRAP_PAGE);
        end
    endfunction

    // Added instruction cycles for a program read
    function [1:0] extra_count;
        input mv;
        input rpt;
        input edge_case;
        begin
            if (!rpt) begin
                extra_count = mv ? `EXTRA_MOVE : `EXTRA_OTHER;
            end else if (edge_case) begin
                extra_count = `EXTRA_REPEAT_EDGE;
            end else begin
                extra_count = `EXTRA_NONE;
            end
        end
    endfunction

    // Byte pick with low byte at even address
    function [`DATA_W-1:0] pick_lane;
        input [`DATA_W-1:0] word;
        input               byte_acc;
        input               odd;
        begin
            if (!byte_acc) begin
                pick_lane = word;
            end else if (odd) begin
                pick_lane = {`PAD_BYTE, word[15:8]};
            end else begin
                pick_lane = {`PAD_BYTE, word[7:0]};
            end
        end
    endfunction

    // ****************************************************************
    // Request decode
    // ****************************************************************
    reg [1:0]              state;
    reg [1:0]              extra_left;
    reg                    hold_prog;
    reg                    hold_write;
    reg                    hold_byte;
    reg                    hold_odd;

    wire [`PAGE_W-1:0] applied_page;
    wire               req_trap;
    wire               req_prog;
    wire               rpt_edge;
    wire [1:0]         req_extra;
    wire [`PROG_ADDR_W-1:0] req_paddr;
    wire [`DATA_W-1:0] prog_word;
    wire [`DATA_W-1:0] next_word;
    wire [`DATA_W-1:0] next_resp;

    assign applied_page = acc_write ? write_page_register : read_page_register;
    assign req_trap     = zero_page_trap(effective_address, applied_page);
    assign req_prog     = route_prog(effective_address, read_page_register,
                                     acc_write);
    assign rpt_edge     = repeat_first | repeat_last | repeat_int_exit |
                          repeat_int_reentry;
    assign req_extra    = extra_count(kind_move, in_repeat, rpt_edge);

    // Page low byte over word offset, word half in bit 0
    assign req_paddr = {read_page_register[`PAGE_SEL_HI:0],
                        effective_address[`EFF_OFS_HI:1],
                        read_page_register[`PAGE_HALF_BIT]};

    // Upper word carries one real byte, phantom byte reads zero
    assign prog_word = prog_upper ?
        {`PAD_BYTE, prog_rdata[`PROG_UPPER_HI:`PROG_UPPER_LO]} :
        prog_rdata[`DATA_W-1:0];
    assign next_word = hold_prog ? prog_word : data_rdata;
    assign next_resp = pick_lane(next_word, hold_byte, hold_odd);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state         <= ST_IDLE;
            extra_left    <= `EXTRA_NONE;
            hold_prog     <= 1'b0;
            hold_write    <= 1'b0;
            hold_byte     <= 1'b0;
            hold_odd      <= 1'b0;
            busy          <= 1'b0;
            resp_valid    <= 1'b0;
            resp_data     <= {`DATA_W{1'b0}};
            addr_err_trap <= 1'b0;
            prog_rd       <= 1'b0;
            prog_addr     <= {`PROG_ADDR_W{1'b0}};
            prog_upper    <= 1'b0;
            data_rd       <= 1'b0;
            data_wr       <= 1'b0;
            data_addr     <= {`EFF_ADDR_W{1'b0}};
            data_be       <= 2'b00;
            data_wdata    <= {`DATA_W{1'b0}};
        end else begin
            resp_valid    <= 1'b0;
            addr_err_trap <= 1'b0;
            prog_rd       <= 1'b0;
            data_rd       <= 1'b0;
            data_wr       <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (acc_valid) begin
                        hold_write <= acc_write;
                        hold_byte  <= acc_byte;
                        hold_odd   <= effective_address[0];
                        if (req_trap) begin
                            addr_err_trap <= 1'b1;
                        end else if (req_prog) begin
                            busy       <= 1'b1;
                            hold_prog  <= 1'b1;
                            prog_rd    <= 1'b1;
                            prog_addr  <= req_paddr;
                            prog_upper <= read_page_register[`PAGE_HALF_BIT];
                            extra_left <= req_extra;
                            state      <= ST_ISSUE;
                        end else begin
                            busy       <= 1'b1;
                            hold_prog  <= 1'b0;
                            data_rd    <= ~acc_write;
                            data_wr    <= acc_write;
                            data_addr  <= effective_address;
                            data_be    <= !acc_byte ? `BE_WORD :
                                          effective_address[0] ? `BE_HIGH :
                                          `BE_LOW;
                            data_wdata <= acc_byte ?
                                          {acc_wdata[7:0], acc_wdata[7:0]} :
                                          acc_wdata;
                            extra_left <= `EXTRA_NONE;
                            state      <= ST_ISSUE;
                        end
                    end
                end
                ST_ISSUE: begin
                    if (hold_write) begin
                        busy       <= 1'b0;
                        resp_valid <= 1'b1;
                        resp_data  <= {`DATA_W{1'b0}};
                        state      <= ST_IDLE;
                    end else begin
                        state <= ST_CAPT;
                    end
                end
                ST_CAPT: begin
                    resp_data <= next_resp;
                    if (extra_left == `EXTRA_NONE) begin
                        busy       <= 1'b0;
                        resp_valid <= 1'b1;
                        state      <= ST_IDLE;
                    end else begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    extra_left <= extra_left - 2'h1;
                    if (extra_left == 2'h1) begin
                        busy       <= 1'b0;
                        resp_valid <= 1'b1;
                        state      <= ST_IDLE;
                    end
                end
                default: begin
                    busy  <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* logic/program_space_data_window_consts.vh */
// Constants for the program-space data window translator
`ifndef PROGRAM_SPACE_DATA_WINDOW_CONSTS_VH
`define PROGRAM_SPACE_DATA_WINDOW_CONSTS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define EFF_ADDR_W        16
`define PAGE_W            10
`define PROG_ADDR_W       23
`define PROG_DATA_W       24
`define DATA_W            16

// ****************************************************************
// Field positions
// ****************************************************************
`define EFF_WINDOW_BIT    15
`define EFF_OFS_HI        14
`define PAGE_ROUTE_BIT    9
`define PAGE_HALF_BIT     8
`define PAGE_SEL_HI       7
`define PROG_UPPER_HI     23
`define PROG_UPPER_LO     16

// ****************************************************************
// Values
// ****************************************************************
`define TRAP_PAGE         10'h000
`define PAGE_RESET        10'h000
`define PAD_BYTE          8'h00
`define BE_LOW            2'b01
`define BE_HIGH           2'b10
`define BE_WORD           2'b11

// ****************************************************************
// Timing counts, in instruction cycles
// ****************************************************************
`define EXTRA_NONE        2'h0
`define EXTRA_MOVE        2'h1
`define EXTRA_OTHER       2'h2
`define EXTRA_REPEAT_EDGE 2'h2

`endif

/* tb/mem_model.sv */
// Program and data memory responder behind the window
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    input  wire logic        sys_clk,
    input  wire logic        prog_rd,
    input  wire logic [22:0] prog_addr,
    input  wire logic        data_rd,
    input  wire logic [15:0] data_addr,
    output var  logic [23:0] prog_rdata,
    output var  logic [15:0] data_rdata
);
    initial prog_rdata = 24'h000000;
    initial data_rdata = 16'h0000;
    // Word one cycle after strobe, inverted junk otherwise
    always @(posedge sys_clk) begin
        prog_rdata <= prog_rd ? {prog_addr[7:0] ^ 8'ha5, prog_addr[15:0]}
                              : ~prog_rdata;
        data_rdata <= data_rd ? data_addr ^ 16'h3c3c : ~data_rdata;
    end
endmodule
`default_nettype wire

/* tb/psdw_asserts.sv */
// Assertion checker for the program-space data window
`timescale 1ns/1ns
`default_nettype none
module psdw_asserts (
    input wire logic        sys_clk, rst_n, acc_valid, acc_write, busy,
    input wire logic        kind_move, in_repeat, repeat_first, repeat_last,
    input wire logic        repeat_int_exit, repeat_int_reentry, prog_rd,
    input wire logic        resp_valid, addr_err_trap, data_rd, data_wr,
    input wire logic [15:0] effective_address,
    input wire logic [9:0]  read_page_register, write_page_register,
    input wire logic [22:0] prog_addr
);
    wire [9:0]  rp = read_page_register;
    wire [15:0] ea = effective_address;
    wire [9:0]  pg = acc_write ? write_page_register : rp;
    wire        go = acc_valid && !busy;
    wire        prg = go && ea[15] && !acc_write && rp[9];
    wire        edg = repeat_first || repeat_last || repeat_int_exit
                      || repeat_int_reentry;
    wire [22:0] pa = {rp[7:0], ea[14:1], rp[8]};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Fetch strobe then answer after 0, 1 or 2 added cycles
    sequence s_n0; prog_rd ##1 !resp_valid ##1 resp_valid; endsequence
    sequence s_n1; prog_rd ##1 !resp_valid[*2] ##1 resp_valid; endsequence
    sequence s_n2; prog_rd ##1 !resp_valid[*3] ##1 resp_valid; endsequence
    property p_trap; go && ea[15] && pg == 10'h000 |=> addr_err_trap
        && !prog_rd; endproperty
    property p_route; prg |=> prog_rd && !data_rd; endproperty
    property p_addr; prg |=> prog_addr == $past(pa); endproperty
    property p_data; go && !ea[15] |=> (data_rd || data_wr) && !prog_rd;
    endproperty
    property p_move; prg && !in_repeat && kind_move |=> s_n1; endproperty
    property p_other; prg && !in_repeat && !kind_move |=> s_n2; endproperty
    property p_redge; prg && in_repeat && edg |=> s_n2; endproperty
    property p_rmid; prg && in_repeat && !edg |=> s_n0; endproperty
    a_trap: assert property (p_trap) else $error("trap missing");
    a_route: assert property (p_route) else $error("no fetch");
    a_addr: assert property (p_addr) else $error("bad address");
    a_data: assert property (p_data) else $error("not data");
    a_move: assert property (p_move) else $error("move timing");
    a_other: assert property (p_other) else $error("other timing");
    a_redge: assert property (p_redge) else $error("edge timing");
    a_rmid: assert property (p_rmid) else $error("loop timing");
endmodule
bind program_space_data_window psdw_asserts u_chk (.sys_clk, .rst_n,
    .acc_valid, .acc_write, .busy, .kind_move, .in_repeat, .repeat_first,
    .repeat_last, .repeat_int_exit, .repeat_int_reentry, .prog_rd,
    .resp_valid, .addr_err_trap, .data_rd, .data_wr, .effective_address,
    .read_page_register, .write_page_register, .prog_addr);
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the program-space data window
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk, rst_n, acc_valid, acc_write, acc_byte, kind_move;
    logic        in_repeat, repeat_first, repeat_last, repeat_int_exit;
    logic        repeat_int_reentry, busy, resp_valid, addr_err_trap;
    logic        prog_rd, prog_upper, data_rd, data_wr;
    logic [15:0] effective_address, acc_wdata, data_rdata, resp_data;
    logic [15:0] data_addr, data_wdata;
    logic [9:0]  read_page_register, write_page_register;
    logic [23:0] prog_rdata;
    logic [22:0] prog_addr;
    logic [1:0]  data_be;
    logic [31:0] r, s;
    logic [9:0]  pgs [4] = '{10'h200, 10'h2ff, 10'h300, 10'h3ff};
    int          mismatches, n_tests;
    program_space_data_window dut (.sys_clk, .rst_n, .acc_valid, .acc_write,
        .acc_byte, .effective_address, .acc_wdata, .read_page_register,
        .write_page_register, .kind_move, .in_repeat, .repeat_first,
        .repeat_last, .repeat_int_exit, .repeat_int_reentry, .prog_rdata,
        .data_rdata, .busy, .resp_valid, .resp_data, .addr_err_trap,
        .prog_rd, .prog_addr, .prog_upper, .data_rd, .data_wr, .data_addr,
        .data_be, .data_wdata);
    mem_model u_mem (.sys_clk, .prog_rd, .prog_addr, .data_rd, .data_addr,
        .prog_rdata, .data_rdata);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [9:0] pick(input logic [1:0] k, input logic [8:0] v);
        pick = k == 2'd0 ? 10'h000 : k == 2'd1 ? {1'b0, v | 9'h001} : {1'b1, v};
    endfunction
    // One access, model result and latency, compare at answer
    task automatic acc(input logic wr, byt, input logic [15:0] ea, wd,
        input logic [9:0] rp, wp, input logic mv, input logic [4:0] q);
        logic [22:0] pa;
        logic [23:0] w;
        logic [15:0] x;
        logic        trap, prg;
        int          n, lat;
        trap = ea[15] && (wr ? wp : rp) == 10'h000;
        prg = ea[15] && !wr && rp[9];
        pa = {rp[7:0], ea[14:1], rp[8]};
        w = {pa[7:0] ^ 8'ha5, pa[15:0]};
        x = prg ? (rp[8] ? {8'h00, w[23:16]} : w[15:0]) : ea ^ 16'h3c3c;
        if (byt) x = {8'h00, ea[0] ? x[15:8] : x[7:0]};
        if (wr) x = 16'h0000;
        lat = trap ? 1 : wr ? 2 : !prg ? 3 : !q[0] ? (mv ? 4 : 5)
            : (|q[4:1] ? 5 : 3);
        @(posedge sys_clk);
        #1;
        {acc_write, acc_byte, effective_address, acc_wdata} = {wr, byt, ea, wd};
        {read_page_register, write_page_register, kind_move} = {rp, wp, mv};
        {repeat_int_reentry, repeat_int_exit, repeat_last, repeat_first,
            in_repeat} = q;
        acc_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b0;
        n = 1;
        while (!resp_valid && !addr_err_trap && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n, lat);
        chk(addr_err_trap, trap);
        if (!trap) chk(resp_data, x);
        if (prg) chk({prog_upper, prog_addr}, {rp[8], pa});
        if (!trap && !prg) chk({data_addr, data_be}, {ea, byt ? (ea[0] ?
            2'b10 : 2'b01) : 2'b11});
        if (wr && !trap) chk(data_wdata, byt ? {2{wd[7:0]}} : wd);
        if (n >= 20) give_verdict;
    endtask
    initial begin
        {acc_valid, acc_write, acc_byte, kind_move, in_repeat} = 5'h00;
        {repeat_first, repeat_last, repeat_int_exit, repeat_int_reentry} = 4'h0;
        {effective_address, acc_wdata} = 32'h0;
        {read_page_register, write_page_register} = 20'h0;
        mismatches = 0;
        n_tests = 0;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        r = $urandom(78185);
        for (int i = 0; i < 16; i++)
            acc(1'b0, i[3], i[2] ? 16'hffff : 16'h8000, 16'h0000, pgs[i[1:0]],
                10'h200, i[0], 5'h00);
        $display("page boundaries done");
        for (int j = 0; j < 5; j++)
            acc(1'b0, 1'b0, 16'h8123, 16'h0000, 10'h345, 10'h200, j[0],
                j == 0 ? 5'h01 : 5'h01 | 5'(1 << j));
        $display("repeat cases done");
        acc(1'b0, 1'b0, 16'h8000, 16'h0000, 10'h000, 10'h3ff, 1'b1, 5'h00);
        acc(1'b1, 1'b0, 16'hc000, 16'h1234, 10'h3ff, 10'h000, 1'b1, 5'h00);
        $display("trap cases done");
        for (int i = 0; i < 400; i++) begin
            r = $urandom;
            s = $urandom;
            acc(r[0], r[1], r[31:16], s[15:0], pick(r[3:2], s[24:16]),
                pick(r[5:4], r[14:6]), r[15], s[29:25]);
        end
        $display("random mix done");
        give_verdict;
    end
endmodule
`default_nettype wire
